// [rtl/sct_cfg.svh]
// register offsets, field positions and reset values
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH
`define SCT_OFF_CR2 8'h55
`define SCT_OFF_CR1 8'h56
`define SCT_OFF_SR 8'h57
`define SCT_OFF_IC1H 8'h58
`define SCT_OFF_IC1L 8'h59
`define SCT_OFF_OC1H 8'h5A
`define SCT_OFF_OC1L 8'h5B
`define SCT_OFF_CNTH 8'h5C
`define SCT_OFF_CNTL 8'h5D
`define SCT_OFF_ACNTH 8'h5E
`define SCT_OFF_ACNTL 8'h5F
`define SCT_OFF_IC2H 8'h60
`define SCT_OFF_IC2L 8'h61
`define SCT_OFF_OC2H 8'h62
`define SCT_OFF_OC2L 8'h63
`define SCT_CR1_RESET 8'h00
`define SCT_CR2_RESET 8'h00
`define SCT_CNT_RESET 16'hFFFC
`define SCT_OC_RESET 16'h8000
`define SCT_CR1_CIE 7
`define SCT_CR1_MIE 6
`define SCT_CR1_OIE 5
`define SCT_CR1_FL2 4
`define SCT_CR1_FL1 3
`define SCT_CR1_LV2 2
`define SCT_CR1_ED1 1
`define SCT_CR1_LV1 0
`define SCT_CR2_PE1 7
`define SCT_CR2_PE2 6
`define SCT_CR2_OPM 5
`define SCT_CR2_PWM 4
`define SCT_CR2_TKH 3
`define SCT_CR2_TKL 2
`define SCT_CR2_ED2 1
`define SCT_CR2_EXE 0
`define SCT_SR_CF1 7
`define SCT_SR_MF1 6
`define SCT_SR_ROF 5
`define SCT_SR_CF2 4
`define SCT_SR_MF2 3
`define SCT_SR_OFF 2
`endif

// [rtl/sct_pkg.sv]
// types for the capture/compare timer
package sct_pkg;
  typedef enum logic [1:0] {
    SCT_TICK_DIV4 = 2'h0,
    SCT_TICK_DIV2 = 2'h1,
    SCT_TICK_DIV8 = 2'h2,
    SCT_TICK_EXT = 2'h3
  } sct_tick_t;
  typedef enum logic [1:0] {
    SCT_MODE_NORMAL = 2'h0,
    SCT_MODE_PULSE = 2'h1,
    SCT_MODE_PWM = 2'h3
  } sct_mode_t;
endpackage

// [rtl/sct_timer.sv]
// 16-bit capture/compare timer with wishbone register access
`timescale 1ns/100ps
`include "sct_cfg.svh"
// Overview of operation
// - all enabled flags share one interrupt request
// - every enabled flag can wake from wait
// - control one bits 7,6,5 gate flag groups
// - force bit 4 copies level two to pin two in normal mode
// - force bit 3 copies level one to pin one in normal mode
// - second match drives level two, pin one in pwm
// - first match drives level one onto pin one
// - capture one edge: 0 falling, 1 rising
// - pin one enable only routes output
// - pin two enable only routes output
// - one-pulse: capture edge triggers timed pulse
// - pwm: first value width, second value period
// - tick select: div4, div2, div8, external
// - external tick absent stops the counter
// - capture two edge: 0 falling, 1 rising
// - external tick edge: 0 falling, 1 rising
// - status 7: capture one in normal mode or pwm period end
// - status 6: first compare match flag
// - status 5: rollover, cleared by counter low only
// - status 4 capture two, 3 second match
// - disable bit freezes counter and levels, clears pin enables
// - pwm mode raises no compare events
// - pwm period end reloads counter initial value
// - pwm and one-pulse both set means pwm
// - one-pulse never sets first match flag
module sct_timer #(
  parameter bit HAS_EXT_TICK = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_in_first_i,
  input wire logic capture_in_second_i,
  input wire logic ext_tick_pin_i,
  output logic compare_out_first_o,
  output logic compare_out_first_oe_o,
  output logic compare_out_second_o,
  output logic compare_out_second_oe_o,
  output logic irq_o,
  output logic wake_o,
  output sct_pkg::sct_mode_t mode_o
);
  import sct_pkg::*;

  logic [7:0] cr1;
  logic [7:0] cr2;
  logic [7:0] sr;
  logic [15:0] cnt;
  logic [15:0] oc1;
  logic [15:0] oc2;
  logic [15:0] oc1_sh;
  logic [15:0] oc2_sh;
  logic [15:0] ic1;
  logic [15:0] ic2;
  logic [7:0] oc1_hi_pend;
  logic [7:0] oc2_hi_pend;
  logic oc1_lock;
  logic oc2_lock;
  logic [2:0] presc;
  logic cap1_d;
  logic cap2_d;
  logic ext_d;
  logic sr_armed;
  logic pulse_on;
  logic lvl1;
  logic lvl2;
  logic tick;
  logic cap1_ev;
  logic cap2_ev;
  logic m1;
  logic m2;
  logic acc;
  logic rd;
  logic wr;
  logic off;
  sct_mode_t mode;
  sct_tick_t tsel;

  assign off = sr[`SCT_SR_OFF];
  assign tsel = sct_tick_t'(cr2[`SCT_CR2_TKH:`SCT_CR2_TKL]);
  always_comb begin
    if (cr2[`SCT_CR2_PWM]) begin
      mode = SCT_MODE_PWM;
    end else if (cr2[`SCT_CR2_OPM]) begin
      mode = SCT_MODE_PULSE;
    end else begin
      mode = SCT_MODE_NORMAL;
    end
  end
  assign mode_o = mode;

  // bus slave: ack one cycle after request, ack drops after one cycle
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = acc && !wb_we_i;
  assign wr = acc && wb_we_i && wb_sel_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 8'h00;
    end else if (rd) begin
      unique case (wb_adr_i)
        `SCT_OFF_CR2: wb_dat_o <= cr2;
        `SCT_OFF_CR1: wb_dat_o <= cr1;
        `SCT_OFF_SR: wb_dat_o <= sr;
        `SCT_OFF_IC1H: wb_dat_o <= ic1[15:8];
        `SCT_OFF_IC1L: wb_dat_o <= ic1[7:0];
        `SCT_OFF_OC1H: wb_dat_o <= oc1[15:8];
        `SCT_OFF_OC1L: wb_dat_o <= oc1[7:0];
        `SCT_OFF_CNTH: wb_dat_o <= cnt[15:8];
        `SCT_OFF_CNTL: wb_dat_o <= cnt[7:0];
        `SCT_OFF_ACNTH: wb_dat_o <= cnt[15:8];
        `SCT_OFF_ACNTL: wb_dat_o <= cnt[7:0];
        `SCT_OFF_IC2H: wb_dat_o <= ic2[15:8];
        `SCT_OFF_IC2L: wb_dat_o <= ic2[7:0];
        `SCT_OFF_OC2H: wb_dat_o <= oc2[15:8];
        `SCT_OFF_OC2L: wb_dat_o <= oc2[7:0];
        default: wb_dat_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr1 <= `SCT_CR1_RESET;
      cr2 <= `SCT_CR2_RESET;
    end else if (wr && wb_adr_i == `SCT_OFF_CR1) begin
      cr1 <= wb_dat_i;
    end else if (wr && wb_adr_i == `SCT_OFF_CR2) begin
      cr2 <= wb_dat_i;
    end
  end

  // compare values: high write locks transfer until low written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc1 <= `SCT_OC_RESET;
      oc2 <= `SCT_OC_RESET;
      oc1_hi_pend <= 8'h80;
      oc2_hi_pend <= 8'h80;
      oc1_lock <= 1'b0;
      oc2_lock <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == `SCT_OFF_OC1H) begin
        oc1_hi_pend <= wb_dat_i;
        oc1_lock <= 1'b1;
      end
      if (wb_adr_i == `SCT_OFF_OC1L) begin
        oc1 <= {oc1_hi_pend, wb_dat_i};
        oc1_lock <= 1'b0;
      end
      if (wb_adr_i == `SCT_OFF_OC2H) begin
        oc2_hi_pend <= wb_dat_i;
        oc2_lock <= 1'b1;
      end
      if (wb_adr_i == `SCT_OFF_OC2L) begin
        oc2 <= {oc2_hi_pend, wb_dat_i};
        oc2_lock <= 1'b0;
      end
    end
  end

  // pwm shadows load at period end so the output never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc1_sh <= `SCT_OC_RESET;
      oc2_sh <= `SCT_OC_RESET;
    end else if (mode != SCT_MODE_PWM || (m2 && tick)) begin
      if (!oc1_lock) begin
        oc1_sh <= oc1;
      end
      if (!oc2_lock) begin
        oc2_sh <= oc2;
      end
    end
  end

  // prescaler and edge detectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc <= 3'h0;
      cap1_d <= 1'b0;
      cap2_d <= 1'b0;
      ext_d <= 1'b0;
    end else begin
      cap1_d <= capture_in_first_i;
      cap2_d <= capture_in_second_i;
      ext_d <= ext_tick_pin_i;
      if (!off) begin
        presc <= presc + 3'h1;
      end
    end
  end

  always_comb begin
    unique case (tsel)
      SCT_TICK_DIV4: tick = presc[1:0] == 2'h3;
      SCT_TICK_DIV2: tick = presc[0];
      SCT_TICK_DIV8: tick = presc == 3'h7;
      SCT_TICK_EXT: tick = HAS_EXT_TICK &&
        (cr2[`SCT_CR2_EXE] ? (ext_tick_pin_i && !ext_d)
                           : (!ext_tick_pin_i && ext_d));
    endcase
    if (off) begin
      tick = 1'b0;
    end
  end

  assign cap1_ev = cr1[`SCT_CR1_ED1] ? (capture_in_first_i && !cap1_d)
                                     : (!capture_in_first_i && cap1_d);
  assign cap2_ev = cr2[`SCT_CR2_ED2] ? (capture_in_second_i && !cap2_d)
                                     : (!capture_in_second_i && cap2_d);
  assign m1 = cnt == oc1_sh;
  assign m2 = cnt == oc2_sh;

  // counter: writes to either counter low byte reset it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= `SCT_CNT_RESET;
    end else if (wr && (wb_adr_i == `SCT_OFF_CNTL ||
                        wb_adr_i == `SCT_OFF_ACNTL)) begin
      cnt <= `SCT_CNT_RESET;
    end else if (mode == SCT_MODE_PULSE && cap1_ev && !off) begin
      cnt <= `SCT_CNT_RESET;
    end else if (tick) begin
      if (mode == SCT_MODE_PWM && m2) begin
        cnt <= `SCT_CNT_RESET;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ic1 <= 16'h0000;
      ic2 <= 16'h0000;
    end else begin
      if (cap1_ev && mode == SCT_MODE_NORMAL) begin
        ic1 <= cnt;
      end
      if (cap2_ev) begin
        ic2 <= cnt;
      end
    end
  end

  // status: read arms, then the data low byte access clears; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_armed <= 1'b0;
    end else if (rd && wb_adr_i == `SCT_OFF_SR) begin
      sr_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr <= 8'h00;
    end else begin
      if (wr && wb_adr_i == `SCT_OFF_SR) begin
        sr[`SCT_SR_OFF] <= wb_dat_i[`SCT_SR_OFF];
      end
      if (acc && sr_armed) begin
        if (wb_adr_i == `SCT_OFF_IC1L) begin
          sr[`SCT_SR_CF1] <= 1'b0;
        end
        if (wb_adr_i == `SCT_OFF_OC1L) begin
          sr[`SCT_SR_MF1] <= 1'b0;
        end
        if (wb_adr_i == `SCT_OFF_CNTL) begin
          sr[`SCT_SR_ROF] <= 1'b0;
        end
        if (wb_adr_i == `SCT_OFF_IC2L) begin
          sr[`SCT_SR_CF2] <= 1'b0;
        end
        if (wb_adr_i == `SCT_OFF_OC2L) begin
          sr[`SCT_SR_MF2] <= 1'b0;
        end
      end
      if ((cap1_ev && mode == SCT_MODE_NORMAL) ||
          (mode == SCT_MODE_PWM && tick && m2)) begin
        sr[`SCT_SR_CF1] <= 1'b1;
      end
      if (tick && m1 && mode == SCT_MODE_NORMAL) begin
        sr[`SCT_SR_MF1] <= 1'b1;
      end
      if (tick && cnt == 16'hFFFF) begin
        sr[`SCT_SR_ROF] <= 1'b1;
      end
      if (cap2_ev) begin
        sr[`SCT_SR_CF2] <= 1'b1;
      end
      if (tick && m2 && mode != SCT_MODE_PWM) begin
        sr[`SCT_SR_MF2] <= 1'b1;
      end
    end
  end

  // output levels on compare and mode events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl1 <= 1'b0;
      lvl2 <= 1'b0;
      pulse_on <= 1'b0;
    end else if (!off) begin
      unique case (mode)
        SCT_MODE_NORMAL: begin
          pulse_on <= 1'b0;
          if (cr1[`SCT_CR1_FL1] || (tick && m1)) begin
            lvl1 <= cr1[`SCT_CR1_LV1];
          end
          if (cr1[`SCT_CR1_FL2] || (tick && m2)) begin
            lvl2 <= cr1[`SCT_CR1_LV2];
          end
        end
        SCT_MODE_PULSE: begin
          if (cap1_ev) begin
            lvl1 <= cr1[`SCT_CR1_LV2];
            pulse_on <= 1'b1;
          end else if (pulse_on && tick && m1) begin
            lvl1 <= cr1[`SCT_CR1_LV1];
            pulse_on <= 1'b0;
          end
        end
        SCT_MODE_PWM: begin
          pulse_on <= 1'b0;
          if (tick && m2) begin
            lvl1 <= cr1[`SCT_CR1_LV2];
          end else if (tick && m1) begin
            lvl1 <= cr1[`SCT_CR1_LV1];
          end
        end
        default: pulse_on <= 1'b0;
      endcase
    end
  end

  // pin enables only route; compare logic keeps running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out_first_o <= 1'b0;
      compare_out_first_oe_o <= 1'b0;
      compare_out_second_o <= 1'b0;
      compare_out_second_oe_o <= 1'b0;
    end else begin
      compare_out_first_o <= lvl1;
      compare_out_second_o <= lvl2;
      compare_out_first_oe_o <= cr2[`SCT_CR2_PE1] && !off;
      compare_out_second_oe_o <= cr2[`SCT_CR2_PE2] && !off;
    end
  end

  assign irq_o = (cr1[`SCT_CR1_CIE] &&
                  (sr[`SCT_SR_CF1] || sr[`SCT_SR_CF2])) ||
                 (cr1[`SCT_CR1_MIE] &&
                  (sr[`SCT_SR_MF1] || sr[`SCT_SR_MF2])) ||
                 (cr1[`SCT_CR1_OIE] && sr[`SCT_SR_ROF]);
  assign wake_o = irq_o;

endmodule // sct_timer

// [verification/sct_timer_assertions.sv]
// concurrent checks on the timer's bus and pin ports
`timescale 1ns/100ps
`include "sct_cfg.svh"
module sct_timer_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic compare_out_first_oe_o,
  input wire logic compare_out_second_oe_o,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire sct_pkg::sct_mode_t mode_o
);
  import sct_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_mode_wr;
    s_req ##0 (wb_we_i && wb_sel_i && wb_adr_i == `SCT_OFF_CR2) ##1 wb_ack_o;
  endsequence
  a_ack_next:
    assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_idle:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
  a_wake_irq:
    assert property (wake_o == irq_o) else $error("wake differs from irq");
  a_reset_quiet:
    assert property ($fell(rst_i) |-> !irq_o && !compare_out_first_oe_o
      && !compare_out_second_oe_o && mode_o == SCT_MODE_NORMAL)
      else $error("outputs active after reset");
  a_unmapped_zero:
    assert property (s_req ##0 (!wb_we_i && (wb_adr_i < `SCT_OFF_CR2 ||
      wb_adr_i > `SCT_OFF_OC2L)) |=> wb_dat_o == 8'h00)
      else $error("unmapped read not zero");
  a_pwm_wins:
    assert property (s_mode_wr ##0 wb_dat_i[4] |=> mode_o == SCT_MODE_PWM)
      else $error("pwm not selected");
  a_pulse_mode:
    assert property (s_mode_wr ##0 (wb_dat_i[5:4] == 2'h2)
      |=> mode_o == SCT_MODE_PULSE) else $error("one-pulse not selected");
endmodule // sct_timer_checker
bind sct_timer sct_timer_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .compare_out_first_oe_o(compare_out_first_oe_o),
  .compare_out_second_oe_o(compare_out_second_oe_o),
  .irq_o(irq_o), .wake_o(wake_o), .mode_o(mode_o));

// [verification/sct_pin_model.sv]
// pin-side model: capture inputs and external tick driven on request
`timescale 1ns/100ps
module sct_pin_model (
  input wire logic clk_i,
  output logic capture_in_first_o,
  output logic capture_in_second_o,
  output logic ext_tick_pin_o
);
  initial begin
    capture_in_first_o = 1'b0;
    capture_in_second_o = 1'b0;
    ext_tick_pin_o = 1'b0;
  end
  task automatic drive(input int pin, input logic level);
    @(posedge clk_i);
    case (pin)
      0: capture_in_first_o <= level;
      1: capture_in_second_o <= level;
      default: ext_tick_pin_o <= level;
    endcase
    // held well past the input synchroniser and a div8 tick
    repeat (10) @(posedge clk_i);
  endtask
endmodule // sct_pin_model

// [verification/tb_sct_timer.sv]
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`include "sct_cfg.svh"
module tb_sct_timer;
  import sct_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0;
  logic [7:0] adr = 8'h00, dat = 8'h00, rdat, q1, q2;
  logic ack, c1, c2, ext, o1, oe1, o2, oe2, irq, wake;
  sct_mode_t mode;
  int errors = 0;
  int check_count = 0;
  always #5 clk_i = ~clk_i;
  sct_pin_model i_pins (.clk_i(clk_i), .capture_in_first_o(c1),
    .capture_in_second_o(c2), .ext_tick_pin_o(ext));
  sct_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .capture_in_first_i(c1), .capture_in_second_i(c2),
    .ext_tick_pin_i(ext), .compare_out_first_o(o1),
    .compare_out_first_oe_o(oe1), .compare_out_second_o(o2),
    .compare_out_second_oe_o(oe2), .irq_o(irq), .wake_o(wake),
    .mode_o(mode));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 1'b1;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check(8'h00, 8'h01, "no ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, q1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m, input string msg);
    xfer(1'b0, a, 8'h00, q1);
    check(q1 & m, e, msg);
  endtask
  task automatic pins(input logic [7:0] e, input string msg);
    repeat (3) @(negedge clk_i);
    check({irq, o1, oe1, o2, oe2, 1'b0, mode}, e, msg);
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SCT_OFF_CNTH, 8'hFF, 8'hFF, "count high");
    rd(`SCT_OFF_CR1, 8'h00, 8'hFF, "cr1 reset");
    rd(`SCT_OFF_CR2, 8'h00, 8'hFF, "cr2 reset");
    rd(`SCT_OFF_SR, 8'h00, 8'hFF, "status reset");
    rd(`SCT_OFF_OC1H, 8'h80, 8'hFF, "match1 high");
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00, 8'hFF, "unmapped");
    wr(`SCT_OFF_CR1, 8'h20);
    wr(`SCT_OFF_CNTL, 8'h00);
    repeat (40) @(posedge clk_i);
    pins(8'h80, "rollover irq");
    wr(`SCT_OFF_CR1, 8'h00);
    pins(8'h00, "masked irq");
    rd(`SCT_OFF_SR, 8'h20, 8'h20, "rollover set");
    rd(`SCT_OFF_ACNTL, 8'h00, 8'h00, "alt low");
    rd(`SCT_OFF_SR, 8'h20, 8'h20, "alt keeps flag");
    rd(`SCT_OFF_CNTL, 8'h00, 8'h00, "count low");
    rd(`SCT_OFF_SR, 8'h00, 8'h20, "rollover clear");
    wr(`SCT_OFF_SR, 8'h04);
    xfer(1'b0, `SCT_OFF_CNTL, 8'h00, q2);
    repeat (30) @(posedge clk_i);
    rd(`SCT_OFF_CNTL, q2, 8'hFF, "frozen count");
    wr(`SCT_OFF_SR, 8'h00);
    wr(`SCT_OFF_CR1, 8'h82);
    i_pins.drive(0, 1'b1);
    rd(`SCT_OFF_SR, 8'h80, 8'h80, "capture1 rise");
    pins(8'h80, "capture irq");
    rd(`SCT_OFF_IC1L, 8'h00, 8'h00, "cap1 low");
    rd(`SCT_OFF_SR, 8'h00, 8'h80, "capture1 clear");
    i_pins.drive(0, 1'b0);
    rd(`SCT_OFF_SR, 8'h00, 8'h80, "capture1 fall");
    i_pins.drive(1, 1'b1);
    rd(`SCT_OFF_SR, 8'h00, 8'h10, "capture2 rise");
    i_pins.drive(1, 1'b0);
    rd(`SCT_OFF_SR, 8'h10, 8'h10, "capture2 fall");
    // first compare at 0002 in normal mode, level one high
    wr(`SCT_OFF_OC1H, 8'h00);
    wr(`SCT_OFF_OC1L, 8'h02);
    wr(`SCT_OFF_CR1, 8'h41);
    wr(`SCT_OFF_CR2, 8'hC0);
    wr(`SCT_OFF_CNTL, 8'h00);
    repeat (40) @(posedge clk_i);
    pins(8'hE8, "match1 level");
    rd(`SCT_OFF_SR, 8'h40, 8'h40, "match1 set");
    rd(`SCT_OFF_OC1L, 8'h02, 8'hFF, "match1 low");
    rd(`SCT_OFF_SR, 8'h00, 8'h40, "match1 clear");
    // pwm: width 0002, period 0005; low before, high after period end
    wr(`SCT_OFF_OC2H, 8'h00);
    wr(`SCT_OFF_OC2L, 8'h05);
    wr(`SCT_OFF_CR1, 8'h04);
    wr(`SCT_OFF_CR2, 8'h90);
    wr(`SCT_OFF_CNTL, 8'h00);
    repeat (30) @(posedge clk_i);
    pins(8'h23, "pwm width low");
    repeat (12) @(posedge clk_i);
    pins(8'h63, "pwm period high");
    rd(`SCT_OFF_CNTH, 8'hFF, 8'hFF, "pwm reload");
    rd(`SCT_OFF_SR, 8'h80, 8'hC8, "pwm flags");
    wr(`SCT_OFF_CR2, 8'h00);
    wr(`SCT_OFF_CR1, 8'h00);
    wr(`SCT_OFF_CR1, 8'h1D);
    wr(`SCT_OFF_CR2, 8'hC0);
    pins(8'h78, "forced levels");
    wr(`SCT_OFF_CR2, 8'h00);
    pins(8'h50, "pins released");
    wr(`SCT_OFF_CR2, 8'h30);
    pins(8'h53, "pwm wins");
    wr(`SCT_OFF_CR2, 8'h20);
    pins(8'h51, "one-pulse");
    wr(`SCT_OFF_CR1, 8'h00);
    for (int e = 0; e < 2; e++) begin
      i_pins.drive(2, !e[0]);
      wr(`SCT_OFF_CR2, 8'h0C | 8'(e));
      wr(`SCT_OFF_CNTL, 8'h00);
      i_pins.drive(2, e[0]);
      rd(`SCT_OFF_CNTL, 8'hFD, 8'hFF, "ext active edge");
      i_pins.drive(2, !e[0]);
      rd(`SCT_OFF_CNTL, 8'hFD, 8'hFF, "ext other edge");
    end
    report_and_stop();
  end
endmodule // tb_sct_timer
